// *** dv/pgs_system_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// System power-sequencing side
// ****************************************************************
module pgs_system_model (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic power_on_i,
  input wire logic ok_drop_i,
  input wire logic [1:0] boot_code_i,
  input wire logic supply_good_i,
  output logic shutdown_n_o,
  output logic system_ok_o,
  output logic [1:0] link_o
);
  // Power-good seen high since power-on
  logic seen_q;
  // System-ok is low while ok_drop_i is high and rises again once it falls, with no power cycle
  // ok raised only once good
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shutdown_n_o <= 1'b0;
      system_ok_o <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      shutdown_n_o <= power_on_i;
      seen_q <= power_on_i & (seen_q | supply_good_i);
      system_ok_o <= power_on_i & seen_q & ~ok_drop_i;
    end
  end
  // boot bits held until good
  // Afterwards the lines carry other traffic, so a stale capture shows
  assign link_o = seen_q ? ~boot_code_i : boot_code_i;
endmodule // pgs_system_model

// *** dv/testbench.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Bench for the sequencer
// ****************************************************************
module testbench
  import pgs_pkg::*;
;
  logic clk, rst_n, psel, pen, pwr, pready, perr, er, sdn, sok, oe, toe, vca, comb, useb, fbz, uvl, rsl;
  logic pon, drop, thl, uv, ga, gb, gout, tout;
  logic [7:0] pa;
  logic [31:0] pwd, prd, rd;
  logic [3:0] pst;
  logic [1:0] lnk, btc;
  logic [2:0] al, bh, sa, sd, dt, sk, ov, zc, ph, pl, hs, ls, bs, dis;
  int failures, compares, cyc;
  // Row: {ov, skip, zc, pwm_h, pwm_l, therm, gnd_a, gnd_b} then {hs, ls, bst, therm_oe, comb, use_b}
  logic [13:0] rows [5];

  pgs_sequencer pgs_sequencer_inst (.ref_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst), .prdata_o(prd), .pready_o(pready),
    .pslverr_o(perr), .shutdown_n_i(sdn), .system_ok_in_i(sok), .voltage_link_clock_i(lnk[1]),
    .voltage_link_data_i(lnk[0]), .conv_above_low_i(al), .conv_below_high_i(bh), .slew_active_i(sa),
    .slew_down_i(sd), .dac_at_target_i(dt), .skip_mode_i(sk), .ov_fault_i(ov), .zero_cross_i(zc),
    .pwm_high_i(ph), .pwm_low_i(pl), .thermal_sense_low_i(thl), .supply_undervoltage_i(uv),
    .remote_ground_sense_a_high_i(ga), .remote_ground_sense_b_high_i(gb), .supply_good_out_o(gout),
    .supply_good_oe_o(oe), .thermal_alert_out_o(tout), .thermal_alert_oe_o(toe), .high_side_gate_o(hs),
    .low_side_gate_o(ls), .boost_switch_o(bs), .discharge_switch_o(dis), .boot_target_code_o(btc),
    .reslew_to_boot_o(rsl), .voltage_code_accept_o(vca), .combined_mode_o(comb),
    .ground_sense_use_b_o(useb), .feedback_hiz_o(fbz), .supply_undervoltage_lock_o(uvl));

  // Pin is pulled up, so the level is high unless pulled low
  pgs_system_model pgs_system_model_inst (.ref_clk_i(clk), .reset_n_i(rst_n), .power_on_i(pon),
    .ok_drop_i(drop), .boot_code_i(2'h2), .supply_good_i(~oe), .shutdown_n_o(sdn), .system_ok_o(sok),
    .link_o(lnk));

  // Free-running 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare with four-state equality so unknowns never match
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task w(input int n);
    repeat (n) @(posedge clk);
  endtask

  // APB transfer; waits for pready however long the slave takes
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      failures++;
      stop_test;
    end
  end

  initial
  begin
    {psel, pen, pwr, pa, pwd, pon, drop, thl, uv, ga, gb} = '0;
    {sa, sd, sk, ov, zc, ph, pl} = '0;
    pst = 4'hf;
    al = 3'h7;
    bh = 3'h7;
    dt = 3'h7;
    failures = 0;
    compares = 0;
    cyc = 0;
    // Skip row with a crossing comes after the plain low-side rows, as a seen crossing keeps the low side off
    rows = '{{8'h10, 6'h20}, {8'h0c, 6'h1c}, {8'h28, 6'h18}, {8'h69, 6'h02}, {8'h92, 6'h1b}};
    rst_n = 1'b0;
    w(16);
    rst_n <= 1'b1;
    // Shutdown beats fault and loop requests
    pl <= 3'h7;
    ov <= 3'h7;
    thl <= 1'b1;
    w(3);
    chk("good_oe", oe, 1);
    chk("low_side", ls, 0);
    chk("high_side", hs, 0);
    chk("thermal_oe", toe, 0);
    chk("discharge", dis, 7);
    chk("fb_hiz", fbz, 1);
    chk("good_out", gout, 0);
    chk("alert_out", tout, 0);
    apb(1'b0, ADDR_CTRL, 0);
    chk("ctrl", rd, CTRL_EN_RESET);
    apb(1'b0, 8'h0c, 0);
    chk("slverr", er, 1);
    $display("shutdown test done");
    // Boot: hold-off of 200 cycles once all targets are reached
    {ov, pl} <= '0;
    thl <= 1'b0;
    pon <= 1'b1;
    w(200);
    chk("good_oe", oe, 1);
    w(15);
    chk("good_oe", oe, 0);
    w(3);
    chk("accept", vca, 1);
    chk("discharge", dis, 0);
    apb(1'b0, ADDR_BOOT, 0);
    chk("boot", rd, 2);
    chk("target", btc, 2);
    $display("boot test done");
    foreach (rows[i])
    begin
      ov <= {3{rows[i][13]}};
      sk <= {3{rows[i][12]}};
      zc <= {3{rows[i][11]}};
      ph <= {3{rows[i][10]}};
      pl <= {3{rows[i][9]}};
      {thl, ga, gb} <= rows[i][8:6];
      w(2);
      chk("high_side", hs, {3{rows[i][5]}});
      chk("low_side", ls, {3{rows[i][4]}});
      chk("boost", bs, {3{rows[i][3]}});
      chk("thermal_oe", toe, rows[i][2]);
      chk("ground", {comb, useb}, rows[i][1:0]);
    end
    {ov, sk, zc, ph, pl} <= '0;
    {thl, ga, gb} <= '0;
    $display("driver table done");
    // A slew releases the pin even with a converter out of range
    al <= 3'h5;
    sa <= 3'h2;
    w(2);
    chk("good_oe", oe, 0);
    sa <= '0;
    w(2);
    chk("good_oe", oe, 1);
    al <= 3'h7;
    w(2);
    chk("good_oe", oe, 0);
    // Skip-mode downslew blanks the upper comparator until back in regulation
    sk <= 3'h1;
    sd <= 3'h1;
    sa <= 3'h1;
    bh <= 3'h6;
    w(2);
    sd <= '0;
    sa <= '0;
    w(3);
    chk("good_oe", oe, 0);
    apb(1'b0, ADDR_STATUS, 0);
    chk("blank", rd[STAT_BLANK_LSB +: NUM_CONV], 1);
    bh <= 3'h7;
    sk <= '0;
    apb(1'b0, ADDR_STATUS, 0);
    chk("blank", rd[STAT_BLANK_LSB +: NUM_CONV], 0);
    $display("blanking test done");
    // System-ok drop: low through the reslew, then 200 more cycles
    drop <= 1'b1;
    dt <= '0;
    sa <= 3'h7;
    w(4);
    chk("good_oe", oe, 1);
    chk("reslew", rsl, 1);
    dt <= 3'h7;
    sa <= '0;
    w(195);
    chk("good_oe", oe, 1);
    w(20);
    chk("good_oe", oe, 0);
    $display("reslew test done");
    // Supply undervoltage latch outlives its cause
    uv <= 1'b1;
    w(2);
    uv <= 1'b0;
    pl <= 3'h7;
    w(3);
    chk("uv_lock", uvl, 1);
    chk("low_side", ls, 0);
    pon <= 1'b0;
    w(4);
    chk("uv_lock", uvl, 0);
    pon <= 1'b1;
    w(4);
    apb(1'b0, ADDR_BOOT, 0);
    chk("boot", rd, 0);
    chk("uv_lock", uvl, 0);
    $display("latch test done");
    // Byte lane 0 gates the enable write; a reset mid-run restores it
    pst <= 4'he;
    apb(1'b1, ADDR_CTRL, 0);
    apb(1'b0, ADDR_CTRL, 0);
    chk("ctrl", rd, CTRL_EN_RESET);
    pst <= 4'hf;
    apb(1'b1, ADDR_CTRL, 0);
    w(2);
    chk("discharge", dis, 7);
    rst_n <= 1'b0;
    w(2);
    chk("fb_hiz", fbz, 1);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, 0);
    chk("ctrl", rd, CTRL_EN_RESET);
    $display("register test done");
    stop_test;
  end
endmodule // testbench

// *** rtl/pgs_pkg.sv ***
// ****************************************************************
// Shared constants for the power-good and fault sequencer
// ****************************************************************
package pgs_pkg;

  // Number of converters watched: two cores and the northbridge
  localparam int NUM_CONV = 3;

  // Oscillator period and the power-good hold-off time
  localparam int CLK_PERIOD_NS = 100;
  localparam int HOLD_TIME_US = 20;
  // Least time, so the count rounds up
  localparam int HOLD_CYCLES = (HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W = 8;
  localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CNT_W'(HOLD_CYCLES - 1);

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BOOT = 8'h08;

  // Control register: per-converter enable field
  localparam int CTRL_EN_LSB = 0;
  localparam logic [NUM_CONV-1:0] CTRL_EN_RESET = 3'h7;

  // Status register field positions
  localparam int STAT_PG = 0;
  localparam int STAT_UV = 1;
  localparam int STAT_COMB = 2;
  localparam int STAT_BOOTV = 3;
  localparam int STAT_HOT = 4;
  localparam int STAT_BLANK_LSB = 5;

  // Boot code width and field position
  localparam int BOOT_W = 2;
  localparam int BOOT_LSB = 0;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_RAMP,
    ST_HOLD,
    ST_RUN,
    ST_RESLEW,
    ST_REHOLD
  } pgs_state_type;

endpackage

// *** rtl/pgs_sequencer.sv ***
// Notes on behaviour
// - Power-good low if any converter not good
// - Release power-good while any slew is active in run state
// - Boot: low until boot voltage, plus 20us
// - Store boot code at first power-good rise
// - Power-good held low during shutdown
// - Skip mode blanks upper comparator on downslew
// - System-ok fall: low during reslew plus 20us
// - High-side gates low in shutdown
// - Low-side gates low in shutdown
// - Overvoltage forces low-side gate high
// - Skip mode: low-side off after zero crossing
// - Boost switch closed only with low-side on
// - Thermal alert low when sense below threshold
// - Thermal alert released during shutdown
// - Supply undervoltage latched until shutdown toggle
// - Discharge switch on when converter shut down
// - Either ground sense high selects combined mode
// - Feedback pin released in shutdown
// - Boot code decoded from link bits early
// - Voltage codes accepted after system-ok rises
`timescale 1ns/1ps
module pgs_sequencer
  import pgs_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // System side
  input wire logic shutdown_n_i,
  input wire logic system_ok_in_i,
  input wire logic voltage_link_clock_i,
  input wire logic voltage_link_data_i,
  // Converter comparators and loop requests
  input wire logic [NUM_CONV-1:0] conv_above_low_i,
  input wire logic [NUM_CONV-1:0] conv_below_high_i,
  input wire logic [NUM_CONV-1:0] slew_active_i,
  input wire logic [NUM_CONV-1:0] slew_down_i,
  input wire logic [NUM_CONV-1:0] dac_at_target_i,
  input wire logic [NUM_CONV-1:0] skip_mode_i,
  input wire logic [NUM_CONV-1:0] ov_fault_i,
  input wire logic [NUM_CONV-1:0] zero_cross_i,
  input wire logic [NUM_CONV-1:0] pwm_high_i,
  input wire logic [NUM_CONV-1:0] pwm_low_i,
  input wire logic thermal_sense_low_i,
  input wire logic supply_undervoltage_i,
  input wire logic remote_ground_sense_a_high_i,
  input wire logic remote_ground_sense_b_high_i,
  // Open-drain pins
  output logic supply_good_out_o,
  output logic supply_good_oe_o,
  output logic thermal_alert_out_o,
  output logic thermal_alert_oe_o,
  // Drivers and switches
  output logic [NUM_CONV-1:0] high_side_gate_o,
  output logic [NUM_CONV-1:0] low_side_gate_o,
  output logic [NUM_CONV-1:0] boost_switch_o,
  output logic [NUM_CONV-1:0] discharge_switch_o,
  // Sequencing outputs
  output logic [BOOT_W-1:0] boot_target_code_o,
  output logic reslew_to_boot_o,
  output logic voltage_code_accept_o,
  output logic combined_mode_o,
  output logic ground_sense_use_b_o,
  output logic feedback_hiz_o,
  output logic supply_undervoltage_lock_o
);

  // ****************************************************************
  // Local signals
  // ****************************************************************
  logic in_sd; // Shutdown asserted
  logic [NUM_CONV-1:0] conv_good; // Per-converter good status
  logic all_good; // Wired-AND result, high when all good
  logic [BOOT_W-1:0] link_code; // Boot code from link pins
  pgs_state_type st_q; // Sequencer state
  logic [HOLD_CNT_W-1:0] hold_cnt_q; // Hold-off counter
  logic sys_ok_q; // Previous system-ok sample
  logic boot_valid_q; // Boot code captured
  logic [BOOT_W-1:0] boot_code_q; // Stored boot code
  logic uv_latch_q; // Supply undervoltage latch
  logic [NUM_CONV-1:0] upper_blank_q; // Upper comparator blanked
  logic [NUM_CONV-1:0] zc_seen_q; // Zero crossing seen since the last high-side request
  logic [NUM_CONV-1:0] conv_en_q; // Software converter enables
  logic pg_low_d; // Next power-good pull-low
  logic [NUM_CONV-1:0] conv_off; // Converter shut down
  logic [NUM_CONV-1:0] low_d; // Next low-side gate
  logic [NUM_CONV-1:0] high_d; // Next high-side gate
  logic apb_wr; // Write takes effect
  logic [31:0] rd_word; // Read mux result

  assign in_sd = !shutdown_n_i;
  assign link_code = {voltage_link_clock_i, voltage_link_data_i};

  // Address decode shared by read data and error answer
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_BOOT);
  endfunction

  // ****************************************************************
  // Power-good evaluation
  // ****************************************************************
  // a blanked upper comparator cannot mark the converter bad
  assign conv_good = conv_above_low_i & (conv_below_high_i | upper_blank_q);
  // every converter must be good to release the line
  assign all_good = &conv_good;

  // Priority: shutdown, forced-low sequence states, slewing, status
  always_comb
  begin
    if (in_sd)
    begin
      pg_low_d = 1'b1;
    end
    // boot ramp, reslew and hold-off windows
    else if (st_q != ST_RUN)
    begin
      pg_low_d = 1'b1;
    end
    // slew controller active releases the line
    else if (|slew_active_i)
    begin
      pg_low_d = 1'b0;
    end
    else
    begin
      pg_low_d = !all_good;
    end
  end

  // ****************************************************************
  // Sequencer state machine
  // ****************************************************************
  // Held in its idle state through shutdown so release restarts boot
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= ST_OFF;
    end
    // shutdown holds the sequence in reset
    else if (in_sd)
    begin
      st_q <= ST_OFF;
    end
    else
    begin
      case (st_q)
        ST_OFF:
        begin
          st_q <= ST_RAMP;
        end
        ST_RAMP:
        begin
          if ((&dac_at_target_i) && !(|slew_active_i))
          begin
            st_q <= ST_HOLD;
          end
        end
        ST_HOLD, ST_REHOLD:
        begin
          if (hold_cnt_q == HOLD_LAST)
          begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          // system-ok fall after boot starts the reslew
          if (sys_ok_q && !system_ok_in_i && boot_valid_q)
          begin
            st_q <= ST_RESLEW;
          end
        end
        ST_RESLEW:
        begin
          // every DAC back at the stored boot code
          if ((&dac_at_target_i) && !(|slew_active_i))
          begin
            st_q <= ST_REHOLD;
          end
        end
        default:
        begin
          st_q <= ST_OFF;
        end
      endcase
    end
  end

  // Hold-off counter, zero whenever no hold window is running
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hold_cnt_q <= '0;
    end
    // counts oscillator cycles only inside a hold window
    else if ((st_q == ST_HOLD || st_q == ST_REHOLD) && !in_sd && hold_cnt_q != HOLD_LAST)
    begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
    else
    begin
      hold_cnt_q <= '0;
    end
  end

  // System-ok history for edge detection
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sys_ok_q <= 1'b0;
    end
    else
    begin
      sys_ok_q <= system_ok_in_i;
    end
  end

  // ****************************************************************
  // Boot code storage
  // ****************************************************************
  // Later system-ok edges leave the stored code alone
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      boot_valid_q <= 1'b0;
      boot_code_q <= '0;
    end
    // rising shutdown input finds the store empty
    else if (in_sd)
    begin
      boot_valid_q <= 1'b0;
      boot_code_q <= '0;
    end
    // first rise of power-good captures the code
    else if (!boot_valid_q && supply_good_oe_o && !pg_low_d)
    begin
      boot_valid_q <= 1'b1;
      boot_code_q <= link_code;
    end
  end

  // live link bits until captured, stored code afterwards
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      boot_target_code_o <= '0;
    end
    else if (boot_valid_q)
    begin
      boot_target_code_o <= boot_code_q;
    end
    else
    begin
      boot_target_code_o <= link_code;
    end
  end

  // ****************************************************************
  // Fault latch and comparator blanking
  // ****************************************************************
  // Only a supply power cycle or shutdown toggle clears it
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      uv_latch_q <= 1'b0;
    end
    else if (in_sd)
    begin
      uv_latch_q <= 1'b0;
    end
    else if (supply_undervoltage_i)
    begin
      uv_latch_q <= 1'b1;
    end
  end

  // Per-converter blanking and zero-cross memory
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CONV; gi++)
    begin : g_conv
      always_ff @(posedge ref_clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          upper_blank_q[gi] <= 1'b0;
        end
        else if (in_sd)
        begin
          upper_blank_q[gi] <= 1'b0;
        end
        // set wins over the re-enable condition
        else if (skip_mode_i[gi] && slew_down_i[gi])
        begin
          upper_blank_q[gi] <= 1'b1;
        end
        // back in regulation re-enables the comparator
        else if (conv_above_low_i[gi] && conv_below_high_i[gi] && !slew_active_i[gi])
        begin
          upper_blank_q[gi] <= 1'b0;
        end
      end

      // Cleared by the next high-side request, which starts a new cycle
      always_ff @(posedge ref_clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          zc_seen_q[gi] <= 1'b0;
        end
        // crossing seen in skip mode turns the low side off
        else if (skip_mode_i[gi] && zero_cross_i[gi])
        begin
          zc_seen_q[gi] <= 1'b1;
        end
        else if (pwm_high_i[gi] || !skip_mode_i[gi])
        begin
          zc_seen_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Gate drive forcing
  // ****************************************************************
  // a converter is down in shutdown, when disabled or on a latched fault
  assign conv_off = {NUM_CONV{in_sd | uv_latch_q}} | ~conv_en_q;

  // Shutdown beats overvoltage so a dead rail never pumps the low side
  always_comb
  begin
    high_d = '0;
    low_d = '0;
    for (int i = 0; i < NUM_CONV; i++)
    begin
      // high side low when off or in overvoltage
      high_d[i] = !conv_off[i] && !ov_fault_i[i] && pwm_high_i[i] && !pwm_low_i[i];
      if (in_sd)
      begin
        low_d[i] = 1'b0;
      end
      else if (ov_fault_i[i])
      begin
        low_d[i] = 1'b1;
      end
      else if (conv_off[i])
      begin
        low_d[i] = 1'b0;
      end
      // no reverse current in skip mode
      else if (skip_mode_i[i] && (zc_seen_q[i] || zero_cross_i[i]))
      begin
        low_d[i] = 1'b0;
      end
      else
      begin
        low_d[i] = pwm_low_i[i] && !high_d[i];
      end
    end
  end

  // Gate, boost and discharge outputs
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      high_side_gate_o <= '0;
      low_side_gate_o <= '0;
      boost_switch_o <= '0;
      discharge_switch_o <= '1;
    end
    else
    begin
      high_side_gate_o <= high_d;
      low_side_gate_o <= low_d;
      // boost charges only while the low side conducts
      boost_switch_o <= low_d;
      discharge_switch_o <= conv_off;
    end
  end

  // ****************************************************************
  // Open-drain pins and status outputs
  // ****************************************************************
  // Open-drain lines only ever drive low
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      supply_good_out_o <= 1'b0;
      supply_good_oe_o <= 1'b1;
      thermal_alert_out_o <= 1'b0;
      thermal_alert_oe_o <= 1'b0;
    end
    else
    begin
      supply_good_out_o <= 1'b0;
      supply_good_oe_o <= pg_low_d;
      thermal_alert_out_o <= 1'b0;
      thermal_alert_oe_o <= !in_sd && thermal_sense_low_i;
    end
  end

  // Sequencing and mode indications
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      reslew_to_boot_o <= 1'b0;
      voltage_code_accept_o <= 1'b0;
      combined_mode_o <= 1'b0;
      ground_sense_use_b_o <= 1'b0;
      feedback_hiz_o <= 1'b1;
      supply_undervoltage_lock_o <= 1'b0;
    end
    else
    begin
      reslew_to_boot_o <= (st_q == ST_RESLEW) || (st_q == ST_REHOLD);
      // link commands honoured once system-ok is up in run
      voltage_code_accept_o <= !in_sd && system_ok_in_i && (st_q == ST_RUN);
      // either sense pin high means combined mode
      combined_mode_o <= remote_ground_sense_a_high_i || remote_ground_sense_b_high_i;
      ground_sense_use_b_o <= remote_ground_sense_a_high_i;
      feedback_hiz_o <= in_sd;
      supply_undervoltage_lock_o <= uv_latch_q;
    end
  end

  // ****************************************************************
  // APB register file
  // ****************************************************************
  assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;

  always_comb
  begin
    rd_word = '0;
    case (paddr_i)
      ADDR_CTRL: rd_word[CTRL_EN_LSB +: NUM_CONV] = conv_en_q;
      ADDR_STATUS:
      begin
        rd_word[STAT_PG] = !supply_good_oe_o;
        rd_word[STAT_UV] = uv_latch_q;
        rd_word[STAT_COMB] = combined_mode_o;
        rd_word[STAT_BOOTV] = boot_valid_q;
        rd_word[STAT_HOT] = thermal_alert_oe_o;
        rd_word[STAT_BLANK_LSB +: NUM_CONV] = upper_blank_q;
      end
      ADDR_BOOT: rd_word[BOOT_LSB +: BOOT_W] = boot_code_q;
      default: rd_word = '0;
    endcase
  end

  // Answer prepared in setup so the access phase has no wait
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end
    else
    begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !is_mapped(paddr_i);
      prdata_o <= (psel_i && !penable_i && !pwrite_i && is_mapped(paddr_i)) ? rd_word : '0;
    end
  end

  // Converter enables, low byte lane only
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      conv_en_q <= CTRL_EN_RESET;
    end
    else if (apb_wr && paddr_i == ADDR_CTRL && pstrb_i[0])
    begin
      conv_en_q <= pwdata_i[CTRL_EN_LSB +: NUM_CONV];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_pg_sd;
    @(posedge ref_clk_i) disable iff (!reset_n_i) in_sd |=> supply_good_oe_o;
  endproperty
  a_pg_sd: assert property (p_pg_sd) else $error("power-good not low in shutdown");

  property p_pg_slew;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (!in_sd && st_q == ST_RUN && (|slew_active_i)) |=> !supply_good_oe_o;
  endproperty
  a_pg_slew: assert property (p_pg_slew) else $error("power-good driven while slewing");

  property p_hold_len;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (st_q == ST_HOLD && $past(st_q) == ST_HOLD && !in_sd) ##1 (st_q == ST_RUN) |->
        $past(hold_cnt_q) == HOLD_LAST;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("boot hold-off ended early");

  property p_hold_low;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (st_q == ST_REHOLD) |=> supply_good_oe_o;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("power-good high during reslew hold");

  property p_boot_cap;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $rose(boot_valid_q) |-> boot_code_q == $past(link_code);
  endproperty
  a_boot_cap: assert property (p_boot_cap) else $error("boot code not captured");

  property p_blank;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (!in_sd && skip_mode_i[0] && slew_down_i[0]) |=> upper_blank_q[0];
  endproperty
  a_blank: assert property (p_blank) else $error("upper comparator not blanked");

  property p_gates_sd;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      in_sd |=> (high_side_gate_o == '0) && (low_side_gate_o == '0);
  endproperty
  a_gates_sd: assert property (p_gates_sd) else $error("gate driven in shutdown");

  property p_ov;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (!in_sd && ov_fault_i[1]) |=> low_side_gate_o[1] && !high_side_gate_o[1];
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage did not force low side");

  property p_boost;
    @(posedge ref_clk_i) disable iff (!reset_n_i) (boost_switch_o & (~low_side_gate_o | high_side_gate_o)) == '0;
  endproperty
  a_boost: assert property (p_boost) else $error("boost switch closed with low side off");

  property p_hot_sd;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      in_sd |=> !thermal_alert_oe_o;
  endproperty
  a_hot_sd: assert property (p_hot_sd) else $error("thermal alert driven in shutdown");

  property p_uv;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (!in_sd && supply_undervoltage_i) |=> uv_latch_q ##1 supply_undervoltage_lock_o;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not latched");

endmodule // pgs_sequencer
